// ==== src/asf_pkg.sv ====
// Package of constants and types for the amplifier sync and fault control block
package asf_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ASF_CTRL_OFF = 8'h00;  // Control register
  localparam logic [7:0] ASF_STAT_OFF = 8'h04;  // Live status register
  localparam logic [7:0] ASF_IRQ_STAT_OFF = 8'h08;  // Sticky event status
  localparam logic [7:0] ASF_IRQ_EN_OFF = 8'h0C;  // Event enable
  localparam logic [7:0] ASF_IRQ_CLR_OFF = 8'h10;  // Event clear, write only
  localparam logic [7:0] ASF_DIV_OFF = 8'h14;  // Oscillator half-period

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ASF_CTRL_SYNC_OUT_EN_BIT = 0;  // Gates sync pin drive in master mode
  localparam int ASF_STAT_FAULT_BIT = 0;  // Short fault latched
  localparam int ASF_STAT_THERM_BIT = 1;  // Thermal shutdown active
  localparam int ASF_STAT_OUT_EN_BIT = 2;  // Output drive enabled
  localparam int ASF_STAT_MASTER_BIT = 3;  // Master mode selected
  localparam int ASF_EV_SHORT_BIT = 0;  // Event: short latched
  localparam int ASF_EV_THERM_BIT = 1;  // Event: thermal trip
  localparam int ASF_EV_CLK_LOSS_BIT = 2;  // Event: no slave clock edge in window
  localparam int ASF_EV_W = 3;  // Number of events

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [31:0] ASF_CTRL_RST = 32'h0000_0001;  // Sync drive enabled
  localparam logic [15:0] ASF_DIV_RST = 16'h00C8;  // 200 cycles: 250 kHz at 100 MHz
  localparam int ASF_CLK_MHZ = 100;  // Core clock rate
  localparam int ASF_CLK_LOSS_US = 10;  // Slave clock watchdog window, microseconds
  localparam int ASF_CLK_LOSS_CYC = ASF_CLK_LOSS_US * ASF_CLK_MHZ;  // Window in cycles

  // Protection state machine
  typedef enum logic [1:0] {
    ASF_ST_OFF = 2'b00,  // Shutdown low-current state
    ASF_ST_RUN = 2'b01,  // Normal operation
    ASF_ST_FAULT = 2'b10,  // Short latched
    ASF_ST_HOT = 2'b11  // Thermal shutdown
  } asf_state_t;

endpackage

// ==== src/asf_top.sv ====
// Switching clock selection and protection sequencing of a class-D amplifier
// Behaviour
// - Master mode: switching from internal oscillator
// - Master drives sync pin at oscillator rate
// - Slave mode: sync pin input sets switching
// - Short detected: outputs off immediately
// - Short latched until shutdown or mute cycled
// - Persisting short re-latches after clear
// - Fault output high while short latched
// - Rising mute clears fault flag
// - Over-temperature: shutdown, outputs disabled
// - Thermal fault self-clears after cooling
// - Shutdown low mutes, low-current state
// - Mute high disables outputs
`timescale 1ns/1ps
module asf_top (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Control pins
  input wire logic master_slave_select_in,
  input wire logic shutdown_n_in,
  input wire logic mute_in,
  // Analog sensors
  input wire logic short_detect_in,
  input wire logic over_temp_in,
  // Sync pin, two-way
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe_out,
  // Amplifier side
  output logic switch_clk_out,
  output logic out_enable_out,
  output logic low_power_out,
  output logic fault_out,
  output logic irq_out
);
  import asf_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [5:0] meta_r;  // First stage, read only by second stage
  logic [5:0] sync_r;  // Second stage, safe to use
  logic [5:0] pins_w;  // Raw pin bundle, role strap included
  assign pins_w = {master_slave_select_in, sync_in, over_temp_in, short_detect_in, mute_in, shutdown_n_in};

  // Two flops per pin
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      meta_r <= 6'h00;  // Reads as shutdown and slave: no drive until pins are seen
      sync_r <= 6'h00;
    end else begin
      meta_r <= pins_w;
      sync_r <= meta_r;
    end
  end

  logic sdn_ok_w;  // Shutdown pin high
  logic mute_w;  // Mute pin high
  logic short_w;  // Short sensed
  logic hot_w;  // Die above trip (comparator owns hysteresis)
  logic ext_clk_w;  // Synchronised sync pin
  assign sdn_ok_w = sync_r[0];
  assign mute_w = sync_r[1];
  assign short_w = sync_r[2];
  assign hot_w = sync_r[3];
  assign ext_clk_w = sync_r[4];
  logic msel_w;  // Synchronised role strap, high for master
  assign msel_w = sync_r[5];

  // Previous samples for edge detection
  logic mute_d_r;
  logic sdn_d_r;
  logic ext_d_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mute_d_r <= 1'b0;
      sdn_d_r <= 1'b0;  // Matches the synchroniser's reset level
      ext_d_r <= 1'b0;
    end else begin
      mute_d_r <= mute_w;
      sdn_d_r <= sdn_ok_w;
      ext_d_r <= ext_clk_w;
    end
  end
  logic mute_rise_w;
  logic sdn_rise_w;
  logic ext_edge_w;
  assign mute_rise_w = mute_w & ~mute_d_r;
  assign sdn_rise_w = sdn_ok_w & ~sdn_d_r;
  assign ext_edge_w = ext_clk_w ^ ext_d_r;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [31:0] ctrl_r;
  logic [15:0] div_r;
  logic [ASF_EV_W-1:0] ev_en_r;
  logic [ASF_EV_W-1:0] ev_stat_r;
  logic [ASF_EV_W-1:0] ev_set_w;
  logic wr_pend_r;  // Write data phase pending
  logic [7:0] wr_addr_r;  // Latched write address
  logic addr_ph_w;
  assign addr_ph_w = hsel_in & htrans_in[1] & hready_in;

  // Capture write address phase
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ph_w & hwrite_in;
      wr_addr_r <= haddr_in[7:0];
    end
  end

  logic wr_ctrl_w;
  logic wr_en_w;
  logic wr_clr_w;
  logic wr_div_w;
  assign wr_ctrl_w = wr_pend_r & (wr_addr_r == ASF_CTRL_OFF);
  assign wr_en_w = wr_pend_r & (wr_addr_r == ASF_IRQ_EN_OFF);
  assign wr_clr_w = wr_pend_r & (wr_addr_r == ASF_IRQ_CLR_OFF);
  assign wr_div_w = wr_pend_r & (wr_addr_r == ASF_DIV_OFF);

  // Writable registers; divider never below 1
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_r <= ASF_CTRL_RST;
      div_r <= ASF_DIV_RST;
      ev_en_r <= '0;
    end else begin
      if (wr_ctrl_w) ctrl_r <= {31'h0000_0000, hwdata_in[ASF_CTRL_SYNC_OUT_EN_BIT]};
      if (wr_div_w) div_r <= (hwdata_in[15:0] == 16'h0000) ? 16'h0001 : hwdata_in[15:0];
      if (wr_en_w) ev_en_r <= hwdata_in[ASF_EV_W-1:0];
    end
  end

  // Sticky events: set wins over clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) ev_stat_r <= '0;
    else ev_stat_r <= (ev_stat_r & ~({ASF_EV_W{wr_clr_w}} & hwdata_in[ASF_EV_W-1:0])) | ev_set_w;
  end

  // ************************************************************
  // Protection state machine
  // ************************************************************
  asf_state_t st_r;
  asf_state_t st_nxt;
  logic clear_w;  // Fault release by mute rise or shutdown cycle
  assign clear_w = mute_rise_w | sdn_rise_w;

  // Next state, shutdown overrides in every state, thermal overrides short only from run
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ASF_ST_OFF: begin
        if (sdn_ok_w) st_nxt = ASF_ST_RUN;
      end
      ASF_ST_RUN: begin
        if (!sdn_ok_w) st_nxt = ASF_ST_OFF;
        else if (hot_w) st_nxt = ASF_ST_HOT;
        else if (short_w) st_nxt = ASF_ST_FAULT;
      end
      ASF_ST_FAULT: begin
        if (!sdn_ok_w) st_nxt = ASF_ST_OFF;
        else if (clear_w) st_nxt = ASF_ST_RUN;
      end
      ASF_ST_HOT: begin
        if (!sdn_ok_w) st_nxt = ASF_ST_OFF;
        else if (!hot_w) st_nxt = ASF_ST_RUN;
      end
      default: st_nxt = ASF_ST_OFF;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) st_r <= ASF_ST_OFF;
    else st_r <= st_nxt;
  end

  logic drive_nxt_w;  // Output drive allowed next cycle
  assign drive_nxt_w = (st_nxt == ASF_ST_RUN) & ~mute_w;

  // ************************************************************
  // Switching clock: oscillator or slave input
  // ************************************************************
  logic [15:0] osc_cnt_r;
  logic osc_r;
  logic osc_wrap_w;
  assign osc_wrap_w = (osc_cnt_r >= div_r - 16'h0001);

  // Internal oscillator, half-period set by div_r
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      osc_cnt_r <= 16'h0000;
      osc_r <= 1'b0;
    end else if (osc_wrap_w) begin
      osc_cnt_r <= 16'h0000;
      osc_r <= ~osc_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
    end
  end

  // Slave clock watchdog
  logic [$clog2(ASF_CLK_LOSS_CYC+1)-1:0] loss_cnt_r;
  logic loss_hit_w;
  assign loss_hit_w = ~msel_w & (loss_cnt_r == ($bits(loss_cnt_r))'(ASF_CLK_LOSS_CYC - 1));
  always_ff @(posedge core_clk_in) begin
    if (rst_in || msel_w || ext_edge_w || loss_hit_w) loss_cnt_r <= '0;
    else loss_cnt_r <= loss_cnt_r + 1'b1;
  end

  logic sw_nxt_w;
  assign sw_nxt_w = msel_w ? osc_r : ext_clk_w;

  // Event sources
  assign ev_set_w[ASF_EV_SHORT_BIT] = (st_nxt == ASF_ST_FAULT) & (st_r != ASF_ST_FAULT);
  assign ev_set_w[ASF_EV_THERM_BIT] = (st_nxt == ASF_ST_HOT) & (st_r != ASF_ST_HOT);
  assign ev_set_w[ASF_EV_CLK_LOSS_BIT] = loss_hit_w;

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      switch_clk_out <= 1'b0;
      sync_out <= 1'b0;
      sync_oe_out <= 1'b0;
      out_enable_out <= 1'b0;
      low_power_out <= 1'b1;
      fault_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      switch_clk_out <= sw_nxt_w & drive_nxt_w;
      sync_out <= osc_r;
      sync_oe_out <= msel_w & ctrl_r[ASF_CTRL_SYNC_OUT_EN_BIT];
      out_enable_out <= drive_nxt_w;
      low_power_out <= (st_nxt == ASF_ST_OFF);
      fault_out <= (st_nxt == ASF_ST_FAULT);
      irq_out <= |((ev_stat_r | ev_set_w) & ev_en_r);
    end
  end

  // Bus read mux, registered, zero wait states
  logic [31:0] stat_w;
  logic [31:0] rd_w;
  assign stat_w = {28'h0000000, msel_w, out_enable_out,
                   (st_r == ASF_ST_HOT), (st_r == ASF_ST_FAULT)};
  assign rd_w = (haddr_in[7:0] == ASF_CTRL_OFF) ? ctrl_r :
                (haddr_in[7:0] == ASF_STAT_OFF) ? stat_w :
                (haddr_in[7:0] == ASF_IRQ_STAT_OFF) ? {29'h00000000, ev_stat_r} :
                (haddr_in[7:0] == ASF_IRQ_EN_OFF) ? {29'h00000000, ev_en_r} :
                (haddr_in[7:0] == ASF_DIV_OFF) ? {16'h0000, div_r} : 32'h0000_0000;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (addr_ph_w && !hwrite_in) hrdata_out <= rd_w;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_short_off;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_r == ASF_ST_RUN && sdn_ok_w && !hot_w && short_w) |=> !out_enable_out;
  endproperty
  a_short_off: assert property (p_short_off) else $error("short did not disable outputs");

  property p_fault_hold;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_r == ASF_ST_FAULT && sdn_ok_w && !mute_rise_w) |=> (st_r == ASF_ST_FAULT);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault released without cycling");

  property p_relatch;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_r == ASF_ST_RUN && sdn_ok_w && !hot_w && short_w) |=> fault_out;
  endproperty
  a_relatch: assert property (p_relatch) else $error("short not latched");

  property p_fault_pin;
    @(posedge core_clk_in) disable iff (rst_in) $rose(fault_out) |-> $past(short_w) && !out_enable_out;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault output mismatch");

  property p_mute_clear;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_r == ASF_ST_FAULT && sdn_ok_w && mute_rise_w) |=> !fault_out;
  endproperty
  a_mute_clear: assert property (p_mute_clear) else $error("mute rise did not clear fault");

  property p_hot;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_r == ASF_ST_RUN && sdn_ok_w && hot_w) |=> (st_r == ASF_ST_HOT) && !out_enable_out;
  endproperty
  a_hot: assert property (p_hot) else $error("thermal trip ignored");

  property p_cool;
    @(posedge core_clk_in) disable iff (rst_in)
      (st_r == ASF_ST_HOT && sdn_ok_w && !hot_w) |=> (st_r == ASF_ST_RUN);
  endproperty
  a_cool: assert property (p_cool) else $error("thermal fault did not self-clear");

  property p_sdn;
    @(posedge core_clk_in) disable iff (rst_in) !sdn_ok_w |=> low_power_out && !out_enable_out;
  endproperty
  a_sdn: assert property (p_sdn) else $error("shutdown not honoured");

  property p_mute;
    @(posedge core_clk_in) disable iff (rst_in) mute_w |=> !out_enable_out;
  endproperty
  a_mute: assert property (p_mute) else $error("mute did not disable outputs");

  property p_sync_dir;
    @(posedge core_clk_in) disable iff (rst_in) !$past(msel_w) |-> !sync_oe_out;
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync driven in slave mode");

  c_fault: cover property (@(posedge core_clk_in) disable iff (rst_in) fault_out ##[1:50] !fault_out);
  c_hot: cover property (@(posedge core_clk_in) disable iff (rst_in) st_r == ASF_ST_HOT);
  c_slave: cover property (@(posedge core_clk_in) disable iff (rst_in)
    !msel_w && out_enable_out && ext_edge_w);

endmodule  // asf_top

// ==== verif/asf_host_model.sv ====
// Host GPIO and sync line partner of the amplifier sync and fault control block
`timescale 1ns/1ps
module asf_host_model (
  // Host controls
  input wire logic gpio_clk_en_in,
  input wire logic ext_mute_in,
  input wire logic retry_in,
  // Amplifier pins
  input wire logic fault_in,
  input wire logic sync_oe_in,
  input wire logic sync_drv_in,
  output logic sync_pin_out,
  output logic mute_out
);
  // ************************************************************
  // Slave square wave, 125 ns period, still while disabled
  // ************************************************************
  logic gpio_clk;
  initial begin
    gpio_clk = 1'b0;
    forever begin
      #62.5;
      // Toggles only while the host is supplying the clock, steady period
      if (gpio_clk_en_in) begin
        gpio_clk = ~gpio_clk;
      end
    end
  end
  // Sync wire level: the amplifier wins while it drives the pin
  assign sync_pin_out = sync_oe_in ? sync_drv_in : gpio_clk;
  // Mute is the OR of the host request and the fault pin gated by retry_in
  assign mute_out = ext_mute_in | (retry_in & fault_in);
endmodule  // asf_host_model

// ==== verif/amp_sync_and_fault_control_bench.sv ====
// Self-checking bench for the amplifier sync and fault control block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module amp_sync_and_fault_control_bench;
  import asf_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk, rst, hsel, hwrite, msel, sd_n, ext_mute, retry, short_det, hot, gclk_en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hrdy, hresp, sync_pin, sync_drv, sync_oe, sw_clk, out_en, low_pwr, fault, irq, mute, pv, psel;
  int miscompares = 0;
  int compares = 0;
  int n, tog, gap;
  wire logic probe = psel ? sw_clk : sync_drv;  // Signal whose half-period is measured
  // Core clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  asf_top u_asf_top (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .master_slave_select_in(msel), .shutdown_n_in(sd_n),
    .mute_in(mute), .short_detect_in(short_det), .over_temp_in(hot), .sync_in(sync_pin), .sync_out(sync_drv),
    .sync_oe_out(sync_oe), .switch_clk_out(sw_clk), .out_enable_out(out_en), .low_power_out(low_pwr),
    .fault_out(fault), .irq_out(irq));
  asf_host_model u_asf_host_model (.gpio_clk_en_in(gclk_en), .ext_mute_in(ext_mute), .retry_in(retry),
    .fault_in(fault), .sync_oe_in(sync_oe), .sync_drv_in(sync_drv), .sync_pin_out(sync_pin), .mute_out(mute));
  // ************************************************************
  // Tasks
  // ************************************************************
  // Prints counts and verdict, then ends the run
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Bounded wait for hready sampled high
  task automatic hwait();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      summarize();
    end
  endtask
  // One single-word AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'h2;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Cycles between two changes of the probed clock
  task automatic span();
    for (int k = 0; k < 2; k++) begin
      pv = probe;
      gap = 0;
      do begin
        @(posedge clk);
        gap++;
      end while (probe === pv && gap < 500);
    end
  endtask
  // Guard against a hang
  initial begin
    #900us;
    miscompares++;
    summarize();
  end
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    {rst, msel} = 2'b11;
    {hsel, hwrite, sd_n, ext_mute, retry, short_det, hot, gclk_en, psel} = 9'h000;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'h2};
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    // Reset values, unmapped place, shutdown state
    bus(1'b0, ASF_CTRL_OFF, 32'h0);
    `CHK(rd, ASF_CTRL_RST)
    bus(1'b0, ASF_DIV_OFF, 32'h0);
    `CHK(rd[15:0], ASF_DIV_RST)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
    `CHK(low_pwr, 1'b1)
    `CHK(out_en, 1'b0)
    $display("test reset done");
    // Master role, the preferred one on a shared sync line
    sd_n <= 1'b1;
    bus(1'b1, ASF_DIV_OFF, 32'h4);
    cyc(6);
    `CHK(out_en, 1'b1)
    `CHK(sync_oe, 1'b1)
    span();
    `CHK(gap, 4)
    psel <= 1'b1;
    span();
    `CHK(gap, 4)
    $display("test master done");
    // Slave role: switching follows the host square wave
    msel <= 1'b0;
    gclk_en <= 1'b1;
    cyc(20);
    `CHK(sync_oe, 1'b0)
    tog = 0;
    repeat (200) begin
      pv = sw_clk;
      @(posedge clk);
      if (sw_clk !== pv) tog++;
    end
    `CHK(tog >= 31 && tog <= 33, 1'b1)
    gclk_en <= 1'b0;
    cyc(1100);
    bus(1'b0, ASF_IRQ_STAT_OFF, 32'h0);
    `CHK(rd[ASF_EV_CLK_LOSS_BIT], 1'b1)
    bus(1'b1, ASF_IRQ_CLR_OFF, 32'h7);
    msel <= 1'b1;
    $display("test slave done");
    // Short: latched, flagged, interrupt raised and cleared
    bus(1'b1, ASF_IRQ_EN_OFF, 32'h1);
    short_det <= 1'b1;
    cyc(6);
    `CHK(fault, 1'b1)
    `CHK(out_en, 1'b0)
    `CHK(irq, 1'b1)
    bus(1'b1, ASF_IRQ_CLR_OFF, 32'h1);
    cyc(2);
    `CHK(irq, 1'b0)
    // Mute rise with the short still there clears then re-latches
    ext_mute <= 1'b1;
    tog = 0;
    repeat (10) begin
      @(posedge clk);
      if (fault === 1'b0) tog++;
    end
    `CHK(tog > 0, 1'b1)
    `CHK(fault, 1'b1)
    short_det <= 1'b0;
    ext_mute <= 1'b0;
    cyc(6);
    `CHK(fault, 1'b1)
    ext_mute <= 1'b1;
    cyc(8);
    `CHK(fault, 1'b0)
    `CHK(out_en, 1'b0)
    ext_mute <= 1'b0;
    cyc(6);
    `CHK(out_en, 1'b1)
    // Shutdown cycle also clears a latched short
    short_det <= 1'b1;
    cyc(6);
    short_det <= 1'b0;
    sd_n <= 1'b0;
    cyc(6);
    `CHK(fault, 1'b0)
    `CHK(low_pwr, 1'b1)
    sd_n <= 1'b1;
    cyc(6);
    `CHK(out_en, 1'b1)
    $display("test short done");
    // Fault looped to mute retries until the short goes away
    retry <= 1'b1;
    short_det <= 1'b1;
    tog = 0;
    repeat (200) begin
      pv = fault;
      @(posedge clk);
      if (pv === 1'b0 && fault === 1'b1) tog++;
    end
    `CHK(tog > 1, 1'b1)
    short_det <= 1'b0;
    cyc(40);
    `CHK(out_en, 1'b1)
    retry <= 1'b0;
    $display("test retry done");
    // Thermal trip with its interrupt masked, then self recovery
    bus(1'b1, ASF_IRQ_CLR_OFF, 32'h7);
    hot <= 1'b1;
    cyc(6);
    `CHK(out_en, 1'b0)
    bus(1'b0, ASF_STAT_OFF, 32'h0);
    `CHK(rd[ASF_STAT_THERM_BIT], 1'b1)
    bus(1'b0, ASF_IRQ_STAT_OFF, 32'h0);
    `CHK(rd[ASF_EV_THERM_BIT], 1'b1)
    `CHK(irq, 1'b0)
    hot <= 1'b0;
    cyc(6);
    `CHK(out_en, 1'b1)
    $display("test thermal done");
    summarize();
  end
endmodule  // amp_sync_and_fault_control_bench
